// File: rtl/ext_mem_regs.svh
// Purpose: offsets, field positions, reset values and fixed counts of the
//          off-chip memory timing block
// Assumes: byte-wide register port, 8-bit address
// Notes:   definitions only
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH

// register offsets
`define EM_CFG_OFS 8'h00
`define EM_TIM_OFS 8'h01
`define EM_PAGE_OFS 8'h02
`define EM_STAT_OFS 8'h03

// ext_mem_config_reg fields
`define EM_CFG_MUXSEL_BIT 4
`define EM_CFG_MODE_HI 3
`define EM_CFG_MODE_LO 2
`define EM_CFG_ALEW_HI 1
`define EM_CFG_ALEW_LO 0
`define EM_MODE_EXT_ONLY 2'h3
`define EM_CFG_RST 8'h03

// ext_mem_timing_reg fields
`define EM_TIM_SETUP_HI 7
`define EM_TIM_SETUP_LO 6
`define EM_TIM_STRB_HI 5
`define EM_TIM_STRB_LO 2
`define EM_TIM_HOLD_HI 1
`define EM_TIM_HOLD_LO 0
`define EM_TIM_RST 8'hFF

// ext_mem_page_select_reg reset
`define EM_PAGE_RST 8'h00

// status bits
`define EM_STAT_BUSY_BIT 0
`define EM_STAT_EXT_BIT 1
`define EM_STAT_MUX_BIT 2

// fixed overhead of every off-chip move, in system_clock cycles
`define EM_FIXED_CYC 4

`endif

// File: rtl/ext_mem_pkg.sv
// Purpose: types of the off-chip memory timing block
// Assumes: constants come from ext_mem_regs.svh
// Notes:   states are Gray coded along the multiplexed path from ST_IDLE to ST_FIN3
package ext_mem_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_LAUNCH = 4'h1,
		ST_ALE_HI = 4'h3,
		ST_ALE_LO = 4'h2,
		ST_SETUP = 4'h6,
		ST_STROBE = 4'h7,
		ST_HOLD = 4'h5,
		ST_FIN1 = 4'h4,
		ST_FIN2 = 4'hC,
		ST_FIN3 = 4'hD
	} move_state_t;

endpackage : ext_mem_pkg

// File: rtl/phase_counter.sv
// Purpose: down counter that times one phase of an off-chip move
// Assumes: load holds the phase length minus one
// Notes:   last is high in the final cycle of the phase
`timescale 1ns/10ps
module phase_counter (
	input wire logic clock, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic load, // start a new phase
	input wire logic [3:0] load_val, // phase length minus one
	output logic last // final cycle of the phase
);
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;

	// reload wins, otherwise count down and stop at zero
	assign cnt_nxt = load ? load_val : ((cnt_r == 4'h0) ? 4'h0 : cnt_r - 4'h1);
	assign last = (cnt_r == 4'h0);

	// counter state
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 4'h0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : phase_counter

// File: rtl/ext_mem_offchip.sv
// Purpose: external-only address mode and programmable off-chip timing
// Assumes: cpu move requests are one-cycle pulses, ignored while busy
// Notes:   all pins and answers come straight from flip-flops
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "ext_mem_regs.svh"

// Overview of operation
// - with mode field 11 every external_data_move goes off-chip and on-chip xram stays hidden.
// - in external-only mode an 8-bit move ignores ext_mem_page_select_reg.
// - in external-only mode an 8-bit move leaves address lines 15 to 8 undriven.
// - an 8-bit move takes address 7 to 0 from indirect_addr_reg_zero or indirect_addr_reg_one.
// - a 16-bit move takes its whole address from data_pointer_reg.
// - a 16-bit off-chip move drives address 15 to 8, and 7 to 0 on the separate bus when not multiplexed.
// - setup, hold, strobe and latch widths are set in system_clock periods by the two registers.
// - a move lasts the programmed parameters plus four fixed system_clock cycles.
// - the shortest non-multiplexed move lasts five cycles with a one-cycle strobe.
// - multiplexed moves add at least two latch cycles, seven cycles at least.
// - reset loads the longest setup and hold values.
// - bus_mux_select at config bit 4 picks multiplexed or separate address and data.
// - in multiplexed mode the latch strobe is high for the first half of the cycles low address sits on the shared bus.
module ext_mem_offchip (
	input wire logic clock, // system clock, 250 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic ce, // clock enable, freezes all state
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [7:0] reg_rdata, // read data, cycle after reg_rd
	input wire logic mv_req, // external_data_move request pulse
	input wire logic mv_write, // 1 write, 0 read
	input wire logic mv_wide, // 1 16-bit address, 0 8-bit
	input wire logic mv_sel_one, // 8-bit move uses register one
	input wire logic [7:0] mv_wdata, // byte to write
	input wire logic [15:0] data_pointer_reg, // 16-bit address source
	input wire logic [7:0] indirect_addr_reg_zero, // 8-bit address source 0
	input wire logic [7:0] indirect_addr_reg_one, // 8-bit address source 1
	output logic mv_busy, // off-chip move in progress
	output logic mv_done, // pulse, last cycle of a move
	output logic [7:0] mv_rdata, // byte read, valid with mv_done
	output logic onchip_req, // pulse, move handed to on-chip xram
	output logic [7:0] page_sel, // ext_mem_page_select_reg for other modes
	output logic [7:0] addr_hi_out, // address 15:8
	output logic addr_hi_oe, // address 15:8 driven
	output logic [7:0] addr_lo_out, // address 7:0, separate bus
	output logic addr_lo_oe, // address 7:0 driven
	output logic [7:0] ad_out, // data bus, or shared bus when multiplexed
	output logic ad_oe, // data bus driven
	input wire logic [7:0] ad_in, // data bus input
	output logic ale, // address latch strobe, active high
	output logic rd_b, // read strobe, active low
	output logic wr_b // write strobe, active low
);

	// registers
	logic [7:0] ext_mem_config_reg_r;
	logic [7:0] ext_mem_timing_reg_r;
	logic [7:0] ext_mem_page_select_reg_r;
	logic [7:0] reg_rdata_r;

	// move state
	ext_mem_pkg::move_state_t st_r;
	ext_mem_pkg::move_state_t st_nxt;
	logic mv_write_r;
	logic [15:0] mv_addr_r;
	logic mv_hi_drv_r;
	logic [7:0] mv_wdata_r;
	logic mux_r;

	// output flops
	logic mv_busy_r;
	logic mv_done_r;
	logic [7:0] mv_rdata_r;
	logic onchip_req_r;
	logic [7:0] addr_hi_r;
	logic addr_hi_oe_r;
	logic [7:0] addr_lo_r;
	logic addr_lo_oe_r;
	logic [7:0] ad_out_r;
	logic ad_oe_r;
	logic ale_r;
	logic rd_b_r;
	logic wr_b_r;

	// field decode
	wire [1:0] mode = ext_mem_config_reg_r[`EM_CFG_MODE_HI:`EM_CFG_MODE_LO];
	wire ext_only = (mode == `EM_MODE_EXT_ONLY);
	wire mux_sel = ext_mem_config_reg_r[`EM_CFG_MUXSEL_BIT];
	wire [1:0] ale_w = ext_mem_config_reg_r[`EM_CFG_ALEW_HI:`EM_CFG_ALEW_LO];
	wire [1:0] setup_w = ext_mem_timing_reg_r[`EM_TIM_SETUP_HI:`EM_TIM_SETUP_LO];
	wire [3:0] strb_w = ext_mem_timing_reg_r[`EM_TIM_STRB_HI:`EM_TIM_STRB_LO];
	wire [1:0] hold_w = ext_mem_timing_reg_r[`EM_TIM_HOLD_HI:`EM_TIM_HOLD_LO];

	// register port decode
	wire sel_cfg = (reg_addr == `EM_CFG_OFS);
	wire sel_tim = (reg_addr == `EM_TIM_OFS);
	wire sel_page = (reg_addr == `EM_PAGE_OFS);
	wire sel_stat = (reg_addr == `EM_STAT_OFS);
	wire idle = (st_r == ext_mem_pkg::ST_IDLE);
	wire take = mv_req && idle;
	wire go_off = take && ext_only;
	wire go_on = take && !ext_only;

	// status word shows the block's own state
	wire [7:0] stat_word = {5'h00, mux_r, ext_only, !idle};

	// read mux; unmapped offsets read zero
	wire [7:0] rd_mux = sel_cfg ? ext_mem_config_reg_r :
		sel_tim ? ext_mem_timing_reg_r :
		sel_page ? ext_mem_page_select_reg_r :
		sel_stat ? stat_word : 8'h00;

	// effective address: page select plays no part here
	wire [7:0] lo_src = mv_sel_one ? indirect_addr_reg_one : indirect_addr_reg_zero;
	wire [15:0] eff_addr = mv_wide ? data_pointer_reg : {8'h00, lo_src};

	// phase lengths, minus one, in system_clock periods
	function automatic logic [3:0] len_m1(input logic [3:0] n);
		len_m1 = (n == 4'h0) ? 4'h0 : n - 4'h1;
	endfunction : len_m1

	// first state after the address latch phase, zero setup is skipped
	function automatic ext_mem_pkg::move_state_t after_addr(input logic [1:0] su);
		after_addr = (su == 2'h0) ? ext_mem_pkg::ST_SETUP : ext_mem_pkg::ST_SETUP;
		if (su == 2'h0) begin
			after_addr = ext_mem_pkg::ST_STROBE;
		end
	endfunction : after_addr

	// phase counter
	logic ph_load;
	logic [3:0] ph_val;
	logic ph_last;

	phase_counter u_phase (
		.clock(clock),
		.rst_b(rst_b),
		.ce(ce),
		.load(ph_load),
		.load_val(ph_val),
		.last(ph_last)
	);

	// next state: launch and three finishing cycles make the fixed four
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ext_mem_pkg::ST_IDLE: begin
				if (go_off) begin
					st_nxt = ext_mem_pkg::ST_LAUNCH;
				end
			end
			ext_mem_pkg::ST_LAUNCH: begin
				if (mux_r) begin
					st_nxt = ext_mem_pkg::ST_ALE_HI;
				end else begin
					st_nxt = after_addr(setup_w);
				end
			end
			ext_mem_pkg::ST_ALE_HI: begin
				if (ph_last) begin
					st_nxt = ext_mem_pkg::ST_ALE_LO;
				end
			end
			ext_mem_pkg::ST_ALE_LO: begin
				if (ph_last) begin
					st_nxt = after_addr(setup_w);
				end
			end
			ext_mem_pkg::ST_SETUP: begin
				if (ph_last) begin
					st_nxt = ext_mem_pkg::ST_STROBE;
				end
			end
			ext_mem_pkg::ST_STROBE: begin
				if (ph_last) begin
					st_nxt = (hold_w == 2'h0) ? ext_mem_pkg::ST_FIN1 : ext_mem_pkg::ST_HOLD;
				end
			end
			ext_mem_pkg::ST_HOLD: begin
				if (ph_last) begin
					st_nxt = ext_mem_pkg::ST_FIN1;
				end
			end
			ext_mem_pkg::ST_FIN1: begin
				st_nxt = ext_mem_pkg::ST_FIN2;
			end
			ext_mem_pkg::ST_FIN2: begin
				st_nxt = ext_mem_pkg::ST_FIN3;
			end
			ext_mem_pkg::ST_FIN3: begin
				st_nxt = ext_mem_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = ext_mem_pkg::ST_IDLE;
			end
		endcase
	end

	// load the counter whenever a timed phase begins
	wire enter = (st_nxt != st_r);
	assign ph_load = enter;
	always_comb begin
		case (st_nxt)
			ext_mem_pkg::ST_ALE_HI: ph_val = len_m1({2'h0, ale_w} + 4'h1);
			ext_mem_pkg::ST_ALE_LO: ph_val = len_m1({2'h0, ale_w} + 4'h1);
			ext_mem_pkg::ST_SETUP: ph_val = len_m1({2'h0, setup_w});
			ext_mem_pkg::ST_STROBE: ph_val = strb_w;
			ext_mem_pkg::ST_HOLD: ph_val = len_m1({2'h0, hold_w});
			default: ph_val = 4'h0;
		endcase
	end

	// pin levels for the coming cycle
	wire nx_ale_hi = (st_nxt == ext_mem_pkg::ST_ALE_HI);
	wire nx_ale_lo = (st_nxt == ext_mem_pkg::ST_ALE_LO);
	wire nx_setup = (st_nxt == ext_mem_pkg::ST_SETUP);
	wire nx_strobe = (st_nxt == ext_mem_pkg::ST_STROBE);
	wire nx_hold = (st_nxt == ext_mem_pkg::ST_HOLD);
	wire nx_launch = (st_nxt == ext_mem_pkg::ST_LAUNCH);
	wire nx_addr_ph = nx_ale_hi | nx_ale_lo;
	wire nx_data_ph = nx_setup | nx_strobe | nx_hold;
	wire nx_addr_drv = nx_launch | nx_addr_ph | nx_data_ph;
	wire nx_busy = (st_nxt != ext_mem_pkg::ST_IDLE);
	wire nx_done = (st_nxt == ext_mem_pkg::ST_FIN3);
	wire rd_sample = (st_r == ext_mem_pkg::ST_STROBE) && ph_last && !mv_write_r;

	// shared or separate data bus contents
	wire [7:0] nx_ad = (mux_r && nx_addr_ph) ? mv_addr_r[7:0] : mv_wdata_r;
	wire nx_ad_oe = (mux_r && nx_addr_ph) || (nx_data_ph && mv_write_r);

	// register writes; reset gives the longest timings
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ext_mem_config_reg_r <= `EM_CFG_RST;
			ext_mem_timing_reg_r <= `EM_TIM_RST;
			ext_mem_page_select_reg_r <= `EM_PAGE_RST;
		end else if (ce && reg_wr) begin
			if (sel_cfg) begin
				ext_mem_config_reg_r <= reg_wdata;
			end
			if (sel_tim) begin
				ext_mem_timing_reg_r <= reg_wdata;
			end
			if (sel_page) begin
				ext_mem_page_select_reg_r <= reg_wdata;
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_r <= 8'h00;
		end else if (ce) begin
			reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// capture a move; the mux choice is frozen per move, but timing and latch widths are still read live mid-move
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ext_mem_pkg::ST_IDLE;
			mv_write_r <= 1'b0;
			mv_addr_r <= 16'h0000;
			mv_hi_drv_r <= 1'b0;
			mv_wdata_r <= 8'h00;
			mux_r <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			if (go_off) begin
				mv_write_r <= mv_write;
				mv_addr_r <= eff_addr;
				mv_hi_drv_r <= mv_wide;
				mv_wdata_r <= mv_wdata;
				mux_r <= mux_sel;
			end
		end
	end

	// cpu side answers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mv_busy_r <= 1'b0;
			mv_done_r <= 1'b0;
			mv_rdata_r <= 8'h00;
			onchip_req_r <= 1'b0;
		end else if (ce) begin
			mv_busy_r <= nx_busy;
			mv_done_r <= nx_done;
			onchip_req_r <= go_on;
			if (rd_sample) begin
				mv_rdata_r <= ad_in;
			end
		end
	end

	// address pins; upper byte only for 16-bit moves
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_hi_r <= 8'h00;
			addr_hi_oe_r <= 1'b0;
			addr_lo_r <= 8'h00;
			addr_lo_oe_r <= 1'b0;
		end else if (ce) begin
			addr_hi_r <= mv_addr_r[15:8];
			addr_hi_oe_r <= nx_addr_drv && !nx_launch && mv_hi_drv_r;
			addr_lo_r <= mv_addr_r[7:0];
			addr_lo_oe_r <= nx_addr_drv && !nx_launch && !mux_r;
		end
	end

	// data bus, latch strobe and the two strobes
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ad_out_r <= 8'h00;
			ad_oe_r <= 1'b0;
			ale_r <= 1'b0;
			rd_b_r <= 1'b1;
			wr_b_r <= 1'b1;
		end else if (ce) begin
			ad_out_r <= nx_ad;
			ad_oe_r <= nx_ad_oe;
			ale_r <= nx_ale_hi;
			rd_b_r <= !(nx_strobe && !mv_write_r);
			wr_b_r <= !(nx_strobe && mv_write_r);
		end
	end

	// ports from flops
	assign reg_rdata = reg_rdata_r;
	assign mv_busy = mv_busy_r;
	assign mv_done = mv_done_r;
	assign mv_rdata = mv_rdata_r;
	assign onchip_req = onchip_req_r;
	assign page_sel = ext_mem_page_select_reg_r;
	assign addr_hi_out = addr_hi_r;
	assign addr_hi_oe = addr_hi_oe_r;
	assign addr_lo_out = addr_lo_r;
	assign addr_lo_oe = addr_lo_oe_r;
	assign ad_out = ad_out_r;
	assign ad_oe = ad_oe_r;
	assign ale = ale_r;
	assign rd_b = rd_b_r;
	assign wr_b = wr_b_r;

endmodule : ext_mem_offchip

// File: tb/ext_mem_device.sv
// Purpose: behavioural off-chip byte memory with address latch
// Assumes: mux strap follows bus_mux_select
// Notes:   a released bus toggles each cycle so stale data never passes
`timescale 1ns/10ps
module ext_mem_device (
	input wire logic clock, // system clock
	input wire logic mux, // latch wired in
	input wire logic [7:0] addr_lo_out, // separate low address
	input wire logic [7:0] ad_out, // bus from device
	input wire logic ad_oe, // device drives bus
	input wire logic ale, // latch strobe
	input wire logic rd_b, // read strobe, active low
	input wire logic wr_b, // write strobe, active low
	output logic [7:0] ad_in // bus level seen by device
);
	logic [7:0] mem [256];
	logic [7:0] latch_q;
	logic [7:0] last_q;
	wire [7:0] bus = ad_oe ? ad_out : ad_in;
	wire [7:0] a = mux ? latch_q : addr_lo_out;
	// transparent while ale is high, frozen from its fall
	always_latch if (ale) latch_q = bus;
	// drive only while read strobe is low
	assign ad_in = !rd_b ? mem[a] : ~last_q;
	always @(posedge clock) begin
		last_q <= ad_in;
		if (!wr_b) mem[a] <= bus;
	end
endmodule : ext_mem_device

// File: tb/ext_mem_properties.sv
// Purpose: port-level checks of the off-chip move block
// Assumes: config and timing shadowed from register writes
// Notes:   mux and length captured at the request, mode read live from the shadow; the design reads timing fields live
`timescale 1ns/10ps
`include "ext_mem_regs.svh"
module ext_mem_checker (
	input wire logic clock, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic mv_req, // move request
	input wire logic mv_write, // move direction
	input wire logic mv_wide, // 16-bit address
	input wire logic mv_sel_one, // source select
	input wire logic [15:0] data_pointer_reg, // wide source
	input wire logic [7:0] indirect_addr_reg_zero, // narrow source 0
	input wire logic [7:0] indirect_addr_reg_one, // narrow source 1
	input wire logic mv_busy, // move running
	input wire logic mv_done, // last move cycle
	input wire logic onchip_req, // handed on-chip
	input wire logic [7:0] addr_hi_out, // address 15:8
	input wire logic addr_hi_oe, // high address driven
	input wire logic [7:0] addr_lo_out, // address 7:0
	input wire logic addr_lo_oe, // low address driven
	input wire logic [7:0] ad_out, // data or shared bus
	input wire logic ad_oe, // bus driven
	input wire logic ale, // latch strobe
	input wire logic rd_b, // read strobe, active low
	input wire logic wr_b // write strobe, active low
);
	logic [7:0] cfg_r, tim_r, lo_r, hi_r;
	logic wide_r, wr_r, mux_r;
	logic [5:0] len_r, cnt_r;
	wire take = ce && mv_req && !mv_busy;
	wire ext = cfg_r[3:2] == `EM_MODE_EXT_ONLY;
	wire [7:0] lo_nxt = mv_wide ? data_pointer_reg[7:0] :
		(mv_sel_one ? indirect_addr_reg_one : indirect_addr_reg_zero);
	wire [5:0] len_nxt = 6'h05 + 6'(tim_r[7:6]) + 6'(tim_r[5:2]) + 6'(tim_r[1:0]) +
		(cfg_r[4] ? 6'(cfg_r[1:0]) * 6'h02 + 6'h02 : 6'h00);
	// shadow registers and per-move capture; a mid-move write only affects the next move
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{cfg_r, tim_r} <= {`EM_CFG_RST, `EM_TIM_RST};
			{lo_r, hi_r, wide_r, wr_r, mux_r, len_r, cnt_r} <= '0;
		end else if (ce) begin
			if (reg_wr && reg_addr == `EM_CFG_OFS) cfg_r <= reg_wdata;
			if (reg_wr && reg_addr == `EM_TIM_OFS) tim_r <= reg_wdata;
			if (take) {lo_r, hi_r, wide_r, wr_r, mux_r, len_r} <=
				{lo_nxt, data_pointer_reg[15:8], mv_wide, mv_write, cfg_r[4], len_nxt};
			cnt_r <= mv_busy ? cnt_r + 6'h01 : 6'h00;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_strobe_excl: assert property (rd_b || wr_b) else $error("both strobes low");
	a_strobe_dir: assert property (!(rd_b && wr_b) |-> rd_b == wr_r && wr_b == !wr_r)
		else $error("wrong strobe for direction");
	a_onchip_only: assert property (take && !ext |=> onchip_req && !mv_busy)
		else $error("move not handed on-chip");
	a_ext_launch: assert property (take && ext |=> mv_busy && !onchip_req)
		else $error("external move not started");
	a_min_len: assert property ($rose(mv_busy) |-> mv_busy[*5])
		else $error("move shorter than five");
	a_mux_min: assert property ($rose(mv_busy) && mux_r |-> mv_busy[*7])
		else $error("multiplexed move shorter than seven");
	a_len_exact: assert property (mv_done |-> cnt_r == len_r - 6'h01 ##1 !mv_busy)
		else $error("move length wrong");
	a_ale_addr: assert property (ale |-> ad_oe && mux_r && ad_out == lo_r)
		else $error("latch phase bus wrong");
	a_lo_addr: assert property (!(rd_b && wr_b) && !mux_r |-> addr_lo_oe && addr_lo_out == lo_r)
		else $error("low address wrong");
	a_hi_addr: assert property (addr_hi_oe |-> wide_r && addr_hi_out == hi_r)
		else $error("high address wrong");
	a_hi_wide: assert property (!(rd_b && wr_b) && wide_r |-> addr_hi_oe)
		else $error("wide move high address undriven");
endmodule : ext_mem_checker
bind ext_mem_offchip ext_mem_checker u_ext_mem_checker (.*);

// File: tb/testbench.sv
// Purpose: self-checking bench of the off-chip move block
// Assumes: inputs driven just after rising edges; ce dropped once to test the freeze
// Notes:   lengths and read data come from a behavioural model
`timescale 1ns/10ps
`include "ext_mem_regs.svh"
module testbench;
	logic clock, rst_b, ce, reg_wr, reg_rd, mv_req, mv_write, mv_wide, mv_sel_one;
	logic [7:0] reg_addr, reg_wdata, mv_wdata, indirect_addr_reg_zero, indirect_addr_reg_one;
	logic [15:0] data_pointer_reg, a16;
	logic [7:0] cfg_m, tim_m, pg;
	logic [7:0] mem_m [256];
	logic wide;
	wire [7:0] reg_rdata, mv_rdata, page_sel, addr_hi_out, addr_lo_out, ad_out, ad_in;
	wire mv_busy, mv_done, onchip_req, addr_hi_oe, addr_lo_oe, ad_oe, ale, rd_b, wr_b;
	integer miscompares, checks_done, n, k;
	ext_mem_offchip u_ext_mem_offchip (.*);
	ext_mem_device u_ext_mem_device (.mux(cfg_m[4]), .*);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	// one-cycle write strobe; the model follows only the config and timing offsets
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		if (a == `EM_CFG_OFS) cfg_m = d;
		if (a == `EM_TIM_OFS) tim_m = d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wreg
	// read data stands only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 check(16'(reg_rdata), 16'(e));
	endtask : rreg
	task automatic reset_regs;
		rreg(`EM_CFG_OFS, `EM_CFG_RST);
		rreg(`EM_TIM_OFS, `EM_TIM_RST);
		rreg(`EM_PAGE_OFS, `EM_PAGE_RST);
		rreg(`EM_STAT_OFS, 8'h00);
		wreg(8'h07, 8'h5A);
		rreg(8'h07, 8'h00);
	endtask : reset_regs
	function automatic integer exp_len();
		if (cfg_m[3:2] != `EM_MODE_EXT_ONLY) return 0;
		return 5 + tim_m[7:6] + tim_m[5:2] + tim_m[1:0] + (cfg_m[4] ? 2 * (cfg_m[1:0] + 1) : 0);
	endfunction : exp_len
	// one move; the unused address sources carry noise
	task automatic mv(input logic w, input logic wd, input logic [15:0] adr);
		integer len;
		logic s, oc;
		logic [7:0] d;
		len = 0;
		oc = 1'b0;
		s = 1'($urandom);
		d = 8'($urandom);
		@(posedge clock);
		mv_req <= 1'b1;
		mv_write <= w;
		mv_wide <= wd;
		mv_sel_one <= s;
		mv_wdata <= d;
		data_pointer_reg <= wd ? adr : 16'($urandom);
		indirect_addr_reg_zero <= (!wd && !s) ? adr[7:0] : 8'($urandom);
		indirect_addr_reg_one <= (!wd && s) ? adr[7:0] : 8'($urandom);
		@(posedge clock);
		mv_req <= 1'b0;
		for (n = 0; n < 60; n++) begin
			#1;
			oc = oc | (onchip_req === 1'b1);
			if (mv_busy === 1'b1) begin
				len++;
				if (!(rd_b && wr_b)) begin
					check(16'(addr_hi_oe), 16'(wd));
					if (wd) check(16'(addr_hi_out), 16'(adr[15:8]));
					if (!cfg_m[4]) check(16'(addr_lo_out), 16'(adr[7:0]));
				end
			end else if (len > 0 || n > 4) break;
			@(posedge clock);
		end
		if (n == 60) begin
			miscompares++;
			complete_run;
		end
		check(16'(len), 16'(exp_len()));
		check(16'(oc), 16'(exp_len() == 0));
		if (exp_len() > 0 && !w) check(16'(mv_rdata), 16'(mem_m[adr[7:0]]));
		if (exp_len() > 0 && w) mem_m[adr[7:0]] = d;
	endtask : mv
	initial begin
		miscompares = 0;
		checks_done = 0;
		rst_b = 1'b0;
		ce = 1'b1;
		{reg_wr, reg_rd, mv_req, mv_write, mv_wide, mv_sel_one} = '0;
		{reg_addr, reg_wdata, mv_wdata, indirect_addr_reg_zero, indirect_addr_reg_one} = '0;
		data_pointer_reg = 16'h0000;
		cfg_m = `EM_CFG_RST;
		tim_m = `EM_TIM_RST;
		k = $urandom(40);
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		reset_regs();
		// every mode, shortest timing; only mode 11 goes off-chip
		for (k = 0; k < 4; k++) begin
			wreg(`EM_CFG_OFS, 8'(k << 2));
			wreg(`EM_TIM_OFS, 8'h00);
			mv(1'b1, 1'b0, 16'h0012);
			mv(1'b0, 1'b0, 16'h0012);
		end
		wreg(`EM_CFG_OFS, 8'h1C);
		mv(1'b1, 1'b1, 16'hA55A);
		mv(1'b0, 1'b1, 16'hA55A);
		// status shows mode 11 and the latched mux choice once the move is over
		rreg(`EM_STAT_OFS, (8'h01 << `EM_STAT_EXT_BIT) | (8'h01 << `EM_STAT_MUX_BIT));
		// random timing, latch width, mux choice and page select
		for (k = 0; k < 16; k++) begin
			wreg(`EM_CFG_OFS, (8'($urandom) & 8'h13) | 8'h0C);
			wreg(`EM_TIM_OFS, 8'($urandom));
			pg = 8'($urandom);
			wreg(`EM_PAGE_OFS, pg);
			rreg(`EM_TIM_OFS, tim_m);
			check(16'(page_sel), 16'(pg));
			a16 = 16'($urandom);
			wide = 1'($urandom);
			mv(1'b1, wide, a16);
			mv(1'b0, wide, a16);
		end
		// clock enable low: a register write in that window must not land
		@(posedge clock);
		ce <= 1'b0;
		wreg(`EM_PAGE_OFS, ~pg);
		ce <= 1'b1;
		rreg(`EM_PAGE_OFS, pg);
		check(16'(page_sel), 16'(pg));
		// second reset mid-run: longest timing again
		@(posedge clock);
		rst_b <= 1'b0;
		cfg_m = `EM_CFG_RST;
		tim_m = `EM_TIM_RST;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		reset_regs();
		wreg(`EM_CFG_OFS, 8'h0C);
		mv(1'b1, 1'b0, 16'h0033);
		complete_run;
	end
endmodule : testbench
